// [verilog/modulus_move_exec_unit.sv]
// Exec unit for word load, remainders, byte-string copy and raw moves
`timescale 1ns/1ns
`default_nettype none
`include "mme_regs.svh"
// Contract
// - Word load reads memory word into destination; faults trap.
// - Non-relative forms: mode in low nibble, address data in extension.
// - Signed remainder of destination by source into destination.
// - Non-zero signed remainder takes the dividend's sign.
// - Signed remainder sets V only for min over minus one; N Z C clear.
// - Zero divisor raises divide-by-zero trap for both remainders.
// - Unsigned remainder treats operands unsigned, clears all four flags.
// - String copy moves bytes r1 to r2, counting r0 down to zero.
// - On exception r0, r1, r2 reflect only bytes already moved.
// - String copy is macro B4, code 0D, second parcel all zero.
// - Double move copies floating register unchanged, no trap or flags.
// - Double-to-pair move copies raw 64 bits into a register pair.
// - Pair-to-double move copies raw pair into a floating register.
// - Processor read: 0 status word, 1 supervisor word, rest reserved.
// - Single move copies floating register unchanged, no trap or flags.
// - Supervisor-to-user move sets N, Z from result, clears V, C.
// - Supervisor-to-user move in user mode traps as privileged.
// - Single-to-word move copies raw 32 bits into a general register.
// - User-to-supervisor move sets N, Z, clears V, C; privileged.
module modulus_move_exec_unit
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [31:0] instr_pc,
  input wire logic [63:0] instr_bits,
  input wire logic user_mode,
  output logic mem_req,
  output logic mem_we,
  output logic mem_byte,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_err,
  input wire logic [1:0] mem_err_kind,
  output logic done,
  output logic trap_valid,
  output mme_pkg::trap_t trap_code,
  output logic [3:0] cc
);
  import mme_pkg::*;

  state_t state_q, state_d;
  logic [63:0] ins_q, ins_d;
  logic [31:0] pc_q, pc_d, psw_q, psw_d;
  logic [31:0] cnt_q, cnt_d, src_q, src_d, dstp_q, dstp_d;
  logic [31:0] rem_q, rem_d, quo_q, quo_d, dvs_q, dvs_d, hi_q, hi_d;
  logic [5:0] step_q, step_d;
  logic [3:0] dst_q, dst_d;
  logic neg_q, neg_d, ovf_q, ovf_d;
  trap_t pend_q, pend_d, trap_d;
  logic mem_req_d, mem_we_d, mem_byte_d, done_d, trap_valid_d;
  logic [31:0] mem_addr_d, mem_wdata_d;
  logic gw_en, fw_en;
  logic [4:0] gw_addr;
  logic [31:0] gw_data;
  logic [3:0] fw_addr;
  logic [63:0] fw_data;
  logic [31:0] ga_data, gb_data;
  logic [63:0] fa_data;
  logic fifo_valid;
  logic [95:0] fifo_data;

  // Field decode
  wire [7:0] opc = ins_q[15:8];
  wire [7:0] mcode = ins_q[7:0];
  wire [3:0] fa = ins_q[7:4];
  wire [3:0] fb = ins_q[3:0];
  wire [3:0] mx = ins_q[23:20];
  wire [3:0] my = ins_q[19:16];
  wire is_macro = opc == `OPC_MACRO;
  wire movc_ok = is_macro && mcode == `CODE_MOVC && ins_q[31:16] == 16'h0;
  wire su_ok = is_macro && mcode == `CODE_MOVSU && ins_q[31:24] == 8'h00;
  wire us_ok = is_macro && mcode == `CODE_MOVUS && ins_q[31:24] == 8'h00;
  wire loadw_rel = opc == `OPC_LOADW_REL;
  op_t op;
  assign op =
    (loadw_rel || opc == `OPC_LOADW_ADR) ? OP_LOADW :
    opc == `OPC_MODW ? OP_MODW :
    opc == `OPC_MODWU ? OP_MODWU :
    opc == `OPC_MOVD ? OP_MOVD :
    opc == `OPC_MOVS ? OP_MOVS :
    opc == `OPC_DPAIR ? OP_DPAIR :
    opc == `OPC_LPAIR ? OP_LPAIR :
    opc == `OPC_MOVPW ? OP_MOVPW :
    opc == `OPC_MOVSW ? OP_MOVSW :
    movc_ok ? OP_MOVC :
    su_ok ? OP_SU :
    us_ok ? OP_US : OP_ILL;

  // Register read selection; current bank is supervisor when not user
  wire cur_bank = ~user_mode;
  wire [3:0] ga_reg = op == OP_MOVC ? (state_q == S_RD ? 4'h0 : 4'h2) :
    (op == OP_LOADW && !loadw_rel) ? my : fa;
  wire [4:0] ga_addr = op == OP_SU ? {1'b1, mx} :
    op == OP_US ? {1'b0, mx} : {cur_bank, ga_reg};
  wire [3:0] gb_reg = op == OP_MOVC ? 4'h1 :
    op == OP_LPAIR ? 4'(fa + 4'h1) : fb;
  wire [4:0] gb_addr = {cur_bank, gb_reg};

  // Effective address of the word load
  wire [31:0] sx12 = {{20{ins_q[31]}}, ins_q[31:20]};
  wire [31:0] sx16 = {{16{ins_q[31]}}, ins_q[31:16]};
  wire [31:0] ext32 = ins_q[47:16];
  wire mode_ok = fb == `AM_REL12 || fb == `AM_ABS16 || fb == `AM_ABS32 ||
    fb == `AM_PC16 || fb == `AM_PC32;
  wire [31:0] ea = loadw_rel ? ga_data :
    fb == `AM_REL12 ? ga_data + sx12 :
    fb == `AM_ABS16 ? sx16 :
    fb == `AM_ABS32 ? ext32 :
    fb == `AM_PC16 ? pc_q + sx16 : pc_q + ext32;
  wire [3:0] ld_dst = loadw_rel ? fb : fa;

  // Remainder operands: divisor is w1 (port a), dividend w2 (port b)
  wire signed_op = op == OP_MODW;
  wire dvd_neg = signed_op & gb_data[31];
  wire dvs_neg = signed_op & ga_data[31];
  wire [31:0] dvd_abs = dvd_neg ? 32'h0 - gb_data : gb_data;
  wire [31:0] dvs_abs = dvs_neg ? 32'h0 - ga_data : ga_data;
  wire min_by_m1 = signed_op && gb_data == 32'h80000000 &&
    ga_data == 32'hFFFFFFFF;
  wire [32:0] trial = {rem_q, quo_q[31]} - {1'b0, dvs_q};
  wire [31:0] rem_final = neg_q ? 32'h0 - rem_q : rem_q;

  // Processor register read; reserved selectors give zero
  wire [31:0] ssw_val = `SSW_RESET | ({31'h0, user_mode} << `SSW_USER);
  wire [31:0] preg_val = fa == `PREG_PSW ? psw_q :
    fa == `PREG_SSW ? ssw_val : 32'h0;

  wire trap_t mem_trap = mem_err_kind == 2'h0 ? TRAP_PAGE :
    mem_err_kind == 2'h1 ? TRAP_RDPROT :
    mem_err_kind == 2'h2 ? TRAP_WRPROT : TRAP_MEM;
  wire pop = state_q == S_IDLE;

  mme_fifo #(.W(96), .D(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk), .resetn(resetn),
    .in_valid(instr_valid), .in_ready(instr_ready),
    .in_data({instr_pc, instr_bits}),
    .out_valid(fifo_valid), .out_ready(pop), .out_data(fifo_data)
  );
  mme_regfile #(.W(32), .N(32)) u_gpr (
    .sys_clk(sys_clk), .resetn(resetn),
    .ra_addr(ga_addr), .rb_addr(gb_addr),
    .ra_data(ga_data), .rb_data(gb_data),
    .we(gw_en), .wa(gw_addr), .wd(gw_data)
  );
  mme_regfile #(.W(64), .N(16)) u_fpr (
    .sys_clk(sys_clk), .resetn(resetn),
    .ra_addr(fa), .rb_addr(fb),
    .ra_data(fa_data), .rb_data(),
    .we(fw_en), .wa(fw_addr), .wd(fw_data)
  );

  always_comb begin
    state_d = state_q;
    ins_d = ins_q;
    pc_d = pc_q;
    psw_d = psw_q;
    cnt_d = cnt_q;
    src_d = src_q;
    dstp_d = dstp_q;
    rem_d = rem_q;
    quo_d = quo_q;
    dvs_d = dvs_q;
    hi_d = hi_q;
    step_d = step_q;
    dst_d = dst_q;
    neg_d = neg_q;
    ovf_d = ovf_q;
    pend_d = pend_q;
    mem_req_d = mem_req ? ~mem_ack : state_q inside {S_CRD, S_CWR};
    mem_we_d = mem_we;
    mem_byte_d = mem_byte;
    mem_addr_d = mem_addr;
    mem_wdata_d = mem_wdata;
    done_d = 1'b0;
    trap_valid_d = 1'b0;
    trap_d = trap_code;
    gw_en = 1'b0;
    gw_addr = {cur_bank, fb};
    gw_data = 32'h0;
    fw_en = 1'b0;
    fw_addr = fb;
    fw_data = fa_data;
    case (state_q)
      S_IDLE: begin
        if (fifo_valid) begin
          pc_d = fifo_data[95:64];
          ins_d = fifo_data[63:0];
          state_d = S_RD;
        end
      end
      S_RD: begin
        state_d = op == OP_MOVC ? S_RD2 : S_EXEC;
      end
      S_RD2: begin
        cnt_d = ga_data;
        src_d = gb_data;
        state_d = S_EXEC;
      end
      S_EXEC: begin
        state_d = S_IDLE;
        done_d = 1'b1;
        case (op)
          OP_LOADW: begin
            done_d = 1'b0;
            if (loadw_rel || mode_ok) begin
              dst_d = ld_dst;
              mem_req_d = 1'b1;
              mem_we_d = 1'b0;
              mem_byte_d = 1'b0;
              mem_addr_d = ea;
              state_d = S_MEMW;
            end else begin
              trap_valid_d = 1'b1;
              trap_d = TRAP_ILLEGAL;
            end
          end
          OP_MODW, OP_MODWU: begin
            done_d = 1'b0;
            if (ga_data == 32'h0) begin
              trap_valid_d = 1'b1;
              trap_d = TRAP_DIVZERO;
            end else begin
              rem_d = 32'h0;
              quo_d = dvd_abs;
              dvs_d = dvs_abs;
              neg_d = dvd_neg;
              ovf_d = min_by_m1;
              step_d = `DIV_STEPS;
              dst_d = fb;
              state_d = S_DIV;
            end
          end
          OP_MOVD, OP_MOVS: begin
            fw_en = 1'b1;
          end
          OP_DPAIR: begin
            gw_en = 1'b1;
            gw_data = fa_data[31:0];
            hi_d = fa_data[63:32];
            done_d = 1'b0;
            state_d = S_HI;
          end
          OP_LPAIR: begin
            fw_en = 1'b1;
            fw_data = {gb_data, ga_data};
          end
          OP_MOVPW: begin
            gw_en = 1'b1;
            gw_data = preg_val;
          end
          OP_MOVSW: begin
            gw_en = 1'b1;
            gw_data = fa_data[31:0];
          end
          OP_SU, OP_US: begin
            if (user_mode) begin
              done_d = 1'b0;
              trap_valid_d = 1'b1;
              trap_d = TRAP_PRIV;
            end else begin
              gw_en = 1'b1;
              gw_addr = {op == OP_US, my};
              gw_data = ga_data;
              psw_d[`PSW_N] = ga_data[31];
              psw_d[`PSW_Z] = ga_data == 32'h0;
              psw_d[`PSW_V] = 1'b0;
              psw_d[`PSW_C] = 1'b0;
            end
          end
          OP_MOVC: begin
            dstp_d = ga_data;
            pend_d = TRAP_NONE;
            if (cnt_q != 32'h0) begin
              done_d = 1'b0;
              mem_req_d = 1'b1;
              mem_we_d = 1'b0;
              mem_byte_d = 1'b1;
              mem_addr_d = src_q;
              state_d = S_CRD;
            end
          end
          default: begin
            done_d = 1'b0;
            trap_valid_d = 1'b1;
            trap_d = TRAP_ILLEGAL;
          end
        endcase
      end
      S_DIV: begin
        if (step_q != 6'h00) begin
          rem_d = trial[32] ? {rem_q[30:0], quo_q[31]} : trial[31:0];
          quo_d = {quo_q[30:0], ~trial[32]};
          step_d = step_q - 6'h01;
        end else begin
          gw_en = 1'b1;
          gw_addr = {cur_bank, dst_q};
          gw_data = rem_final;
          psw_d[`PSW_N] = 1'b0;
          psw_d[`PSW_Z] = 1'b0;
          psw_d[`PSW_V] = ovf_q;
          psw_d[`PSW_C] = 1'b0;
          done_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_MEMW: begin
        if (mem_ack) begin
          state_d = S_IDLE;
          if (mem_err) begin
            trap_valid_d = 1'b1;
            trap_d = mem_trap;
          end else begin
            gw_en = 1'b1;
            gw_addr = {cur_bank, dst_q};
            gw_data = mem_rdata;
            done_d = 1'b1;
          end
        end
      end
      S_CRD: begin
        if (mem_ack) begin
          if (mem_err) begin
            pend_d = mem_trap;
            state_d = S_WB0;
          end else begin
            mem_we_d = 1'b1;
            mem_addr_d = dstp_q;
            mem_wdata_d = {24'h0, mem_rdata[7:0]};
            state_d = S_CWR;
          end
        end
      end
      S_CWR: begin
        if (mem_ack) begin
          if (mem_err) begin
            pend_d = mem_trap;
            state_d = S_WB0;
          end else begin
            cnt_d = cnt_q - 32'h1;
            src_d = src_q + 32'h1;
            dstp_d = dstp_q + 32'h1;
            if (cnt_q == 32'h1) begin
              state_d = S_WB0;
            end else begin
              mem_we_d = 1'b0;
              mem_addr_d = src_q + 32'h1;
              state_d = S_CRD;
            end
          end
        end
      end
      S_WB0: begin
        gw_en = 1'b1;
        gw_addr = {cur_bank, 4'h0};
        gw_data = cnt_q;
        state_d = S_WB1;
      end
      S_WB1: begin
        gw_en = 1'b1;
        gw_addr = {cur_bank, 4'h1};
        gw_data = src_q;
        state_d = S_WB2;
      end
      S_WB2: begin
        gw_en = 1'b1;
        gw_addr = {cur_bank, 4'h2};
        gw_data = dstp_q;
        trap_valid_d = pend_q != TRAP_NONE;
        trap_d = pend_q != TRAP_NONE ? pend_q : trap_code;
        done_d = pend_q == TRAP_NONE;
        state_d = S_IDLE;
      end
      S_HI: begin
        gw_en = 1'b1;
        gw_addr = {cur_bank, 4'(fb + 4'h1)};
        gw_data = hi_q;
        done_d = 1'b1;
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      ins_q <= 64'h0;
      pc_q <= 32'h0;
      psw_q <= `PSW_RESET;
      dst_q <= 4'h0;
      step_q <= 6'h00;
      pend_q <= TRAP_NONE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_byte <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 32'h0;
      done <= 1'b0;
      trap_valid <= 1'b0;
      trap_code <= TRAP_NONE;
      cc <= 4'h0;
      cnt_q <= 32'h0;
      src_q <= 32'h0;
      dstp_q <= 32'h0;
      rem_q <= 32'h0;
      quo_q <= 32'h0;
      dvs_q <= 32'h0;
      hi_q <= 32'h0;
      neg_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ins_q <= ins_d;
      pc_q <= pc_d;
      psw_q <= psw_d;
      dst_q <= dst_d;
      step_q <= step_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      src_q <= src_d;
      dstp_q <= dstp_d;
      rem_q <= rem_d;
      quo_q <= quo_d;
      dvs_q <= dvs_d;
      hi_q <= hi_d;
      neg_q <= neg_d;
      ovf_q <= ovf_d;
      mem_req <= mem_req_d;
      mem_we <= mem_we_d;
      mem_byte <= mem_byte_d;
      mem_addr <= mem_addr_d;
      mem_wdata <= mem_wdata_d;
      done <= done_d;
      trap_valid <= trap_valid_d;
      trap_code <= trap_d;
      cc <= psw_d[3:0];
    end
  end
endmodule
`default_nettype wire

// [verilog/mme_regs.svh]
// Encodings, field positions, reset values and counts for the exec unit
`ifndef MME_REGS_SVH
`define MME_REGS_SVH
`define OPC_LOADW_REL 8'h60
`define OPC_LOADW_ADR 8'h61
`define OPC_MODW 8'h9A
`define OPC_MODWU 8'h9C
`define OPC_MOVD 8'h26
`define OPC_MOVS 8'h24
`define OPC_DPAIR 8'h2E
`define OPC_LPAIR 8'h2F
`define OPC_MOVPW 8'h11
`define OPC_MOVSW 8'h2C
`define OPC_MACRO 8'hB4
`define CODE_MOVC 8'h0D
`define CODE_MOVSU 8'h32
`define CODE_MOVUS 8'h33
`define AM_REL12 4'hA
`define AM_ABS16 4'h3
`define AM_ABS32 4'h1
`define AM_PC16 4'h5
`define AM_PC32 4'h9
`define PREG_PSW 4'h0
`define PREG_SSW 4'h1
`define PSW_N 3
`define PSW_Z 2
`define PSW_V 1
`define PSW_C 0
`define SSW_USER 31
`define PSW_RESET 32'h0
`define SSW_RESET 32'h0
`define DIV_STEPS 6'h20
`define FIFO_DEPTH 8
`endif

// [verilog/mme_pkg.sv]
// Types shared by the exec unit files
package mme_pkg;
  typedef enum {
    S_IDLE, S_RD, S_RD2, S_EXEC, S_DIV, S_MEMW, S_CRD, S_CWR,
    S_WB0, S_WB1, S_WB2, S_HI
  } state_t;
  typedef enum {
    OP_ILL, OP_LOADW, OP_MODW, OP_MODWU, OP_MOVD, OP_MOVS, OP_DPAIR,
    OP_LPAIR, OP_MOVPW, OP_MOVSW, OP_MOVC, OP_SU, OP_US
  } op_t;
  typedef enum logic [3:0] {
    TRAP_NONE, TRAP_PAGE, TRAP_RDPROT, TRAP_WRPROT, TRAP_MEM,
    TRAP_DIVZERO, TRAP_PRIV, TRAP_ILLEGAL
  } trap_t;
endpackage

// [verilog/mme_fifo.sv]
// Instruction FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module mme_fifo #(
  parameter int W = 96,
  parameter int D = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_ready & (cnt_q != '0);
  wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
    end else begin
      wp_q <= push ? AW'((wp_q + 1'b1) % D) : wp_q;
      rp_q <= pop ? AW'((rp_q + 1'b1) % D) : rp_q;
      cnt_q <= cnt_d;
      in_ready <= cnt_d != (AW+1)'(D);
    end
  end
endmodule
`default_nettype wire

// [verilog/mme_regfile.sv]
// Register bank memory: two registered read ports, one write port
`timescale 1ns/1ns
`default_nettype none
module mme_regfile #(
  parameter int W = 32,
  parameter int N = 32
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [$clog2(N)-1:0] ra_addr,
  input wire logic [$clog2(N)-1:0] rb_addr,
  output logic [W-1:0] ra_data,
  output logic [W-1:0] rb_data,
  input wire logic we,
  input wire logic [$clog2(N)-1:0] wa,
  input wire logic [W-1:0] wd
);
  logic [W-1:0] mem_q [N];
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem_q[wa] <= wd;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ra_data <= '0;
      rb_data <= '0;
    end else begin
      ra_data <= mem_q[ra_addr];
      rb_data <= mem_q[rb_addr];
    end
  end
endmodule
`default_nettype wire

// [dv/mem_model.sv]
// Behavioural memory with wait states and a fault injected at one address
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic mem_err,
  output logic [1:0] mem_err_kind,
  input wire logic [7:0] wait_cycles,
  input wire logic fault_en,
  input wire logic [31:0] fault_addr,
  input wire logic [1:0] fault_kind
);
  logic [7:0] mem [0:511];
  logic [7:0] cnt;
  logic [31:0] rd_log;
  wire logic [8:0] a = mem_addr[8:0];
  wire logic hit = fault_en && mem_addr == fault_addr;
  wire logic busy = mem_req && !mem_ack;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 8'h00;
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_err_kind <= 2'h0;
      mem_rdata <= 32'h5A5A5A5A;
    end else if (busy && cnt >= wait_cycles) begin
      cnt <= 8'h00;
      mem_ack <= 1'b1;
      mem_err <= hit;
      mem_err_kind <= fault_kind;
      if (!mem_we) begin
        rd_log <= mem_addr;
        mem_rdata <= {mem[a+9'h3], mem[a+9'h2], mem[a+9'h1], mem[a]};
      end else if (!hit) begin
        mem[a] <= mem_wdata[7:0];
      end
    end else begin
      // Idle data toggles so a stale word never looks valid
      cnt <= busy ? cnt + 8'h01 : 8'h00;
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
  task automatic poke(input int ad, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      mem[ad+i] = v[8*i +: 8];
  endtask
endmodule
`default_nettype wire

// [dv/modulus_move_exec_unit_assertions.sv]
// Port-level checker for the exec unit
`timescale 1ns/1ns
`default_nettype none
module modulus_move_exec_unit_checker
  import mme_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic done,
  input wire logic trap_valid,
  input wire mme_pkg::trap_t trap_code,
  input wire logic [3:0] cc
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  a_req_held_stable:
    assert property (mem_req && !mem_ack |=> mem_req &&
      $stable({mem_addr, mem_we, mem_byte, mem_wdata}))
    else $error("request moved");
  a_req_drop_ack:
    assert property (mem_req && mem_ack |=> !mem_req)
    else $error("request kept");
  a_write_is_byte:
    assert property (mem_req && mem_we |-> mem_byte)
    else $error("word write");
  a_retire_one_way:
    assert property (!(done && trap_valid))
    else $error("done with trap");
  a_done_single:
    assert property (done |=> !done)
    else $error("long done");
  a_trap_single:
    assert property (trap_valid |=> !trap_valid)
    else $error("long trap");
  a_trap_code_set:
    assert property (trap_valid |-> trap_code != TRAP_NONE)
    else $error("no cause");
  a_code_held:
    assert property ($changed(trap_code) |-> trap_valid)
    else $error("code moved");
  a_cc_on_retire:
    assert property ($changed(cc) |->
      (##[0:1] (done || trap_valid)) or $past(done))
    else $error("stray flags");
  a_idle_at_done:
    assert property (done |-> !mem_req)
    else $error("busy at done");
  c_done: cover property (done);
  c_trap: cover property (trap_valid);
  c_full: cover property (instr_valid && !instr_ready);
  c_write: cover property (mem_req && mem_we && mem_ack);
endmodule
`default_nettype wire

// [dv/tb_modulus_move_exec_unit.sv]
// Self-checking bench for the exec unit
`timescale 1ns/1ns
`default_nettype none
module tb_modulus_move_exec_unit;
  import mme_pkg::*;
  localparam time DLY = 5;
  localparam logic [63:0] MOVC = 64'hB40D;
  logic sys_clk, resetn, instr_valid, instr_ready, user_mode, fault_en;
  logic mem_req, mem_we, mem_byte, mem_ack, mem_err, done, trap_valid;
  logic [31:0] instr_pc, mem_addr, mem_wdata, mem_rdata, fault_addr;
  logic [63:0] instr_bits;
  logic [1:0] mem_err_kind, fault_kind;
  logic [7:0] wait_cycles;
  logic [3:0] cc;
  logic full_seen;
  trap_t trap_code;
  int miscompares, cmp_count, n_done;
  modulus_move_exec_unit modulus_move_exec_unit_i (.sys_clk, .resetn,
    .instr_valid, .instr_ready, .instr_pc, .instr_bits, .user_mode,
    .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .mem_err, .mem_err_kind, .done, .trap_valid, .trap_code,
    .cc);
  mem_model mem_model_i (.sys_clk, .resetn, .mem_req, .mem_we, .mem_byte,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .mem_err, .mem_err_kind,
    .wait_cycles, .fault_en, .fault_addr, .fault_kind);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (done === 1'b1)
      n_done <= n_done + 1;
    if (instr_ready === 1'b0)
      full_seen <= 1'b1;
  end
  task automatic tick();
    @(posedge sys_clk);
    #DLY;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic push(input logic [63:0] b);
    instr_bits = b;
    instr_valid = 1'b1;
    while (instr_ready !== 1'b1)
      tick();
    tick();
  endtask
  task automatic run(input logic [63:0] b, input trap_t t);
    int n;
    push(b);
    instr_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && trap_valid !== 1'b1 && n < 900) begin
      tick();
      n++;
    end
    chk("retired", 32'(t == TRAP_NONE), 32'(done));
    chk("trap", 32'(t), trap_valid === 1'b1 ? 32'(trap_code) : 32'h0);
    tick();
  endtask
  function automatic logic [63:0] rr(input logic [7:0] op,
    input logic [3:0] a, b);
    return {48'h0, op, a, b};
  endfunction
  function automatic logic [63:0] su(input logic [3:0] a, b);
    return {40'h0, a, b, 16'hB432};
  endfunction
  task automatic put(input logic [3:0] r, input logic [31:0] v);
    mem_model_i.poke(64, v);
    run({32'h0, 16'h0040, 8'h61, r, 4'h3}, TRAP_NONE);
  endtask
  // Value shows as the source address of a one-byte user copy
  task automatic peek(input logic [3:0] r, input logic [31:0] v);
    run(su(r, 4'h1), TRAP_NONE);
    chk("su_flags", {28'h0, v[31], v == 32'h0, 2'h0}, 32'(cc));
    run(su(4'hE, 4'h0), TRAP_NONE);
    run(su(4'hD, 4'h2), TRAP_NONE);
    user_mode = 1'b1;
    run(MOVC, TRAP_NONE);
    user_mode = 1'b0;
    chk("reg_value", v, mem_model_i.rd_log);
  endtask
  task automatic test_loads();
    put(4'hE, 32'h1);
    put(4'hD, 32'h180);
    put(4'h5, 32'h89ABCDEF);
    peek(4'h5, 32'h89ABCDEF);
    run({16'h0, 32'h40, 8'h61, 4'h6, 4'h1}, TRAP_NONE);
    peek(4'h6, 32'h89ABCDEF);
    run({32'h0, 12'hEC0, 4'hD, 8'h61, 4'h7, 4'hA}, TRAP_NONE);
    peek(4'h7, 32'h89ABCDEF);
    instr_pc = 32'h20;
    run({32'h0, 16'h0020, 8'h61, 4'h8, 4'h5}, TRAP_NONE);
    peek(4'h8, 32'h89ABCDEF);
    run({48'h0, 8'h61, 4'h8, 4'h7}, TRAP_ILLEGAL);
    fault_en = 1'b1;
    fault_addr = 32'h40;
    for (int k = 0; k < 4; k++) begin
      fault_kind = 2'(k);
      if (k != 2)
        run({32'h0, 16'h0040, 8'h61, 8'h93}, trap_t'(k + 1));
    end
    fault_en = 1'b0;
  endtask
  task automatic test_mod();
    logic [31:0] dv [8] = '{32'h4D2, 32'hFFFFFFF9, 32'h7, 32'h80000000,
      32'hFFFFFFF8, 32'hFFFFFFFE, 32'hFFE, 32'h5};
    logic [31:0] ds [8] = '{32'hB, 32'h2, 32'hFFFFFFFE, 32'hFFFFFFFF,
      32'h4, 32'h7, 32'h11, 32'h80000000};
    logic [31:0] rm [8] = '{32'h2, 32'hFFFFFFFF, 32'h1, 32'h0, 32'h0,
      32'h2, 32'hE, 32'h5};
    for (int i = 0; i < 8; i++) begin
      put(4'h3, dv[i]);
      put(4'h4, ds[i]);
      run(rr(i < 5 ? 8'h9A : 8'h9C, 4'h4, 4'h3), TRAP_NONE);
      chk("mod_flags", i == 3 ? 32'h2 : 32'h0, 32'(cc));
      peek(4'h3, rm[i]);
    end
    put(4'h4, 32'h0);
    run(rr(8'h9A, 4'h4, 4'h3), TRAP_DIVZERO);
    run(rr(8'h9C, 4'h4, 4'h3), TRAP_DIVZERO);
  endtask
  task automatic test_preg();
    put(4'hC, 32'h80000000);
    for (int s = 0; s < 16; s = s * 2 + 1) begin
      run(su(4'hC, 4'h5), TRAP_NONE);
      run(rr(8'h11, 4'(s), 4'h9), TRAP_NONE);
      peek(4'h9, s == 0 ? 32'h8 : 32'h0);
    end
  endtask
  task automatic test_raw();
    put(4'h5, 32'h13579BDF);
    put(4'h6, 32'h2468ACE0);
    run(su(4'hC, 4'h5), TRAP_NONE);
    run(rr(8'h2F, 4'h5, 4'h2), TRAP_NONE);
    run(rr(8'h26, 4'h2, 4'h3), TRAP_NONE);
    run(rr(8'h24, 4'h3, 4'h4), TRAP_NONE);
    run(rr(8'h2E, 4'h4, 4'h7), TRAP_NONE);
    run(rr(8'h2C, 4'h4, 4'h9), TRAP_NONE);
    chk("move_flags", 32'h8, 32'(cc));
    peek(4'h7, 32'h13579BDF);
    peek(4'h8, 32'h2468ACE0);
    peek(4'h9, 32'h13579BDF);
  endtask
  task automatic test_priv();
    user_mode = 1'b1;
    run(su(4'h1, 4'h2), TRAP_PRIV);
    run({40'h0, 8'h12, 16'hB433}, TRAP_PRIV);
    user_mode = 1'b0;
    run(su(4'hC, 4'h5), TRAP_NONE);
    run({40'h0, 8'h2A, 16'hB433}, TRAP_NONE);
    chk("us_flags", 32'h0, 32'(cc));
    peek(4'hA, 32'h181);
  endtask
  task automatic test_movc();
    mem_model_i.poke(32'h20, 32'h44332211);
    put(4'h0, 32'h4);
    put(4'h1, 32'h20);
    put(4'h2, 32'h1C0);
    fault_en = 1'b1;
    fault_addr = 32'h1C2;
    fault_kind = 2'h2;
    run(MOVC, TRAP_WRPROT);
    fault_en = 1'b0;
    peek(4'h0, 32'h2);
    peek(4'h1, 32'h22);
    peek(4'h2, 32'h1C2);
    run(MOVC, TRAP_NONE);
    for (int i = 0; i < 4; i++)
      chk("byte", 32'(8'h11 * (i + 1)), 32'(mem_model_i.mem[448+i]));
    run(MOVC, TRAP_NONE);
    run({32'h0, 16'h0001, MOVC[15:0]}, TRAP_ILLEGAL);
    run(rr(8'hFF, 4'h0, 4'h0), TRAP_ILLEGAL);
  endtask
  task automatic test_fifo();
    int base, n;
    wait_cycles = 8'h1E;
    full_seen = 1'b0;
    base = n_done;
    push({32'h0, 16'h0040, 8'h61, 8'h53});
    for (int i = 0; i < 9; i++)
      push(rr(8'h26, 4'h2, 4'h3));
    instr_valid = 1'b0;
    n = 0;
    while (n_done < base + 10 && n < 900) begin
      tick();
      n++;
    end
    chk("fifo_full", 32'h1, 32'(full_seen));
    chk("fifo_retired", 32'(base + 10), 32'(n_done));
    wait_cycles = 8'h00;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(100 * 40000);
    miscompares++;
    end_of_test();
  end
  initial begin
    resetn = 1'b0;
    instr_valid = 1'b0;
    instr_pc = 32'h0;
    instr_bits = 64'h0;
    user_mode = 1'b0;
    wait_cycles = 8'h00;
    fault_en = 1'b0;
    fault_addr = 32'h0;
    fault_kind = 2'h0;
    miscompares = 0;
    cmp_count = 0;
    n_done = 0;
    repeat (8) @(posedge sys_clk);
    #DLY;
    resetn = 1'b1;
    test_loads();
    test_mod();
    test_preg();
    test_raw();
    test_priv();
    test_movc();
    test_fifo();
    end_of_test();
  end
endmodule
bind modulus_move_exec_unit modulus_move_exec_unit_checker #(
  .FIFO_DEPTH(FIFO_DEPTH)) checker_i (.sys_clk, .resetn, .instr_valid,
  .instr_ready, .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata,
  .mem_ack, .done, .trap_valid, .trap_code, .cc);
`default_nettype wire
